// ### logic/sptx_pkg.sv
// shared constants, types and slot arithmetic for the serial audio input link
package sptx_pkg;
    typedef enum logic [1:0] {
        SPTX_FMT_I2S = 2'h0,
        SPTX_FMT_LJ = 2'h1,
        SPTX_FMT_RJ = 2'h3
    } sptx_fmt_t;

    typedef enum logic [1:0] {
        SPTX_W16 = 2'h0,
        SPTX_W18 = 2'h1,
        SPTX_W20 = 2'h2,
        SPTX_W24 = 2'h3
    } sptx_width_t;

    typedef enum logic {
        SPTX_OSR_256 = 1'h0,
        SPTX_OSR_384 = 1'h1
    } sptx_osr_t;

    localparam int unsigned SPTX_WORD_MAX = 24;
    localparam logic [5:0] SPTX_FRAME_SLOTS = 6'h3f;
    localparam logic [4:0] SPTX_HALF_LAST = 5'h1f;
    localparam logic [5:0] SPTX_HALF_SLOTS = 6'h20;
    localparam logic [5:0] SPTX_I2S_DELAY = 6'h01;
    localparam logic [5:0] SPTX_LJ_DELAY = 6'h00;
    localparam int unsigned SPTX_CLK_NS = 8;
    localparam int unsigned SPTX_SCLK_MIN_NS = 80;
    localparam int unsigned SPTX_SCLK_MIN_CYC = (SPTX_SCLK_MIN_NS + SPTX_CLK_NS - 1) / SPTX_CLK_NS;
    localparam int unsigned SPTX_OCLK_MIN_NS = 20;
    localparam int unsigned SPTX_OCLK_MIN_CYC = (SPTX_OCLK_MIN_NS + SPTX_CLK_NS - 1) / SPTX_CLK_NS;
    localparam logic [4:0] SPTX_SCLK_HALF_CYC = 5'h0c;
    localparam logic [2:0] SPTX_OCLK_HALF_256 = 3'h3;
    localparam logic [2:0] SPTX_OCLK_HALF_384 = 3'h2;
    localparam logic [1:0] SPTX_BIPH_DIV_256 = 2'h2;
    localparam logic [1:0] SPTX_BIPH_DIV_384 = 2'h3;

    function automatic logic [5:0] sptx_word_bits(input sptx_width_t w);
        case (w)
            SPTX_W16: sptx_word_bits = 6'h10;
            SPTX_W18: sptx_word_bits = 6'h12;
            SPTX_W20: sptx_word_bits = 6'h14;
            default: sptx_word_bits = 6'h18;
        endcase
    endfunction : sptx_word_bits

    // slot of the msb within a half frame: 1, 0 or 32 minus width
    function automatic logic [5:0] sptx_msb_slot(input sptx_fmt_t f, input sptx_width_t w);
        case (f)
            SPTX_FMT_LJ: sptx_msb_slot = SPTX_LJ_DELAY;
            SPTX_FMT_RJ: sptx_msb_slot = SPTX_HALF_SLOTS - sptx_word_bits(w);
            default: sptx_msb_slot = SPTX_I2S_DELAY;
        endcase
    endfunction : sptx_msb_slot

    // fsync level that marks the left channel
    // reserved code 2 keeps i2s levels, as sptx_msb_slot keeps the i2s delay
    function automatic logic sptx_left_level(input sptx_fmt_t f);
        sptx_left_level = (f == SPTX_FMT_LJ) || (f == SPTX_FMT_RJ);
    endfunction : sptx_left_level
endpackage : sptx_pkg

// ### logic/sptx_if.sv
// three-wire serial audio link plus oversampling clock
`timescale 1ns/10ps
`default_nettype none
interface sptx_if;
    logic sclk;
    logic fsync;
    logic sdata;
    logic oversample_clock;

    modport src (
        output sclk,
        output fsync,
        output sdata,
        output oversample_clock
    );

    modport dev (
        input sclk,
        input fsync,
        input sdata,
        input oversample_clock
    );
endinterface : sptx_if
`default_nettype wire

// ### logic/sptx_dev.sv
// device end: captures left/right words and derives the biphase clock strobe
`timescale 1ns/10ps
`default_nettype none
module sptx_dev (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    sptx_if.dev link,
    input wire logic fmt_sel_in,
    input wire logic [1:0] fmt_in,
    input wire logic [1:0] width_in,
    input wire logic osr_in,
    output logic [23:0] left_out,
    output logic [23:0] right_out,
    output logic valid_out,
    output logic biphase_tick_out
);
    // framing lock: seek an edge, time one half, then trust the slots
    typedef enum logic [1:0] {
        SPTX_LOCK_SEEK = 2'h0,
        SPTX_LOCK_HALF = 2'h1,
        SPTX_LOCK_ON = 2'h3,
        SPTX_LOCK_LOST = 2'h2
    } sptx_lock_t;
    sptx_pkg::sptx_fmt_t fmt;
    sptx_pkg::sptx_width_t width;
    logic sclk_prev_r;
    logic fs_prev_r;
    logic oclk_prev_r;
    logic [4:0] slot_r;
    logic [4:0] slot_nxt;
    logic [23:0] shift_r;
    logic [23:0] left_r;
    logic [23:0] right_r;
    logic valid_r;
    logic [1:0] div_r;
    logic [1:0] div_last;
    logic tick_r;
    logic sclk_rise;
    logic half_start;
    logic in_word;
    logic word_end;
    logic is_left;
    logic [5:0] msb_slot;
    logic [5:0] bits;
    logic slot_wrap;
    sptx_lock_t lock_r;
    sptx_lock_t lock_nxt;

    // completes a word with the wire bit, restarting at a half edge
    function automatic logic [23:0] sptx_fill(input logic [23:0] acc, input logic fresh,
            input logic bit_in);
        sptx_fill = fresh ? {23'h000000, bit_in} : {acc[22:0], bit_in};
    endfunction : sptx_fill

    // format select low falls back to i2s
    // default i2s framing
    assign fmt = fmt_sel_in ? sptx_pkg::sptx_fmt_t'(fmt_in) : sptx_pkg::SPTX_FMT_I2S;
    assign width = sptx_pkg::sptx_width_t'(width_in);
    assign bits = sptx_pkg::sptx_word_bits(width);
    assign msb_slot = sptx_pkg::sptx_msb_slot(fmt, width);

    assign sclk_rise = link.sclk & ~sclk_prev_r;
    assign half_start = link.fsync != fs_prev_r;
    assign slot_nxt = half_start ? 5'h00 : slot_r + 5'h01;
    assign is_left = link.fsync == sptx_pkg::sptx_left_level(fmt);
    assign in_word = ({1'b0, slot_nxt} >= msb_slot) && ({1'b0, slot_nxt} < msb_slot + bits);
    // rj lsb lands on slot 31
    assign word_end = {1'b0, slot_nxt} == msb_slot + bits - 6'h01;

    // a half running past 32 slots with no edge means framing is lost
    assign slot_wrap = sclk_rise && !half_start && (slot_r == sptx_pkg::SPTX_HALF_LAST);

    always_comb begin
        lock_nxt = lock_r;
        case (lock_r)
            SPTX_LOCK_SEEK: begin
                if (sclk_rise && half_start) begin
                    lock_nxt = SPTX_LOCK_HALF;
                end
            end
            SPTX_LOCK_HALF: begin
                if (sclk_rise && half_start && slot_r == sptx_pkg::SPTX_HALF_LAST) begin
                    lock_nxt = SPTX_LOCK_ON;
                end else if (slot_wrap) begin
                    lock_nxt = SPTX_LOCK_SEEK;
                end
            end
            SPTX_LOCK_ON: begin
                if (sclk_rise && half_start && slot_r != sptx_pkg::SPTX_HALF_LAST) begin
                    lock_nxt = SPTX_LOCK_HALF;
                end else if (slot_wrap) begin
                    lock_nxt = SPTX_LOCK_LOST;
                end
            end
            SPTX_LOCK_LOST: begin
                if (sclk_rise && half_start) begin
                    lock_nxt = SPTX_LOCK_HALF;
                end
            end
            default: begin
                lock_nxt = SPTX_LOCK_SEEK;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            lock_r <= SPTX_LOCK_SEEK;
        end else begin
            lock_r <= lock_nxt;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            sclk_prev_r <= 1'b0;
        end else begin
            sclk_prev_r <= link.sclk;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            oclk_prev_r <= 1'b0;
        end else begin
            oclk_prev_r <= link.oversample_clock;
        end
    end

    // fsync level is tracked only at sclk rises so glitches between edges are ignored
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            fs_prev_r <= 1'b0;
            slot_r <= sptx_pkg::SPTX_HALF_LAST;
        end else if (sclk_rise) begin
            fs_prev_r <= link.fsync;
            slot_r <= slot_nxt;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            shift_r <= 24'h000000;
        end else if (sclk_rise && half_start) begin
            shift_r <= {23'h000000, link.sdata & in_word};
        end else if (sclk_rise && in_word) begin
            shift_r <= {shift_r[22:0], link.sdata};
        end
    end

    // words are right-aligned; upper bits zero for narrow widths
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            left_r <= 24'h000000;
            right_r <= 24'h000000;
            valid_r <= 1'b0;
        end else begin
            valid_r <= 1'b0;
            if (sclk_rise && word_end && in_word) begin
                if (is_left) begin
                    left_r <= sptx_fill(shift_r, half_start, link.sdata);
                end else begin
                    right_r <= sptx_fill(shift_r, half_start, link.sdata);
                    // partial pairs after reset or a polarity flip are not announced
                    valid_r <= (lock_r == SPTX_LOCK_ON);
                end
            end
        end
    end

    assign div_last = (osr_in == sptx_pkg::SPTX_OSR_384) ?
        sptx_pkg::SPTX_BIPH_DIV_384 - 2'h1 : sptx_pkg::SPTX_BIPH_DIV_256 - 2'h1;
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            div_r <= 2'h0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (link.oversample_clock && !oclk_prev_r) begin
                if (div_r >= div_last) begin
                    div_r <= 2'h0;
                    tick_r <= 1'b1;
                end else begin
                    div_r <= div_r + 2'h1;
                end
            end
        end
    end

    assign left_out = left_r;
    assign right_out = right_r;
    assign valid_out = valid_r;
    assign biphase_tick_out = tick_r;
endmodule : sptx_dev
`default_nettype wire

// ### logic/sptx_src.sv
// source end: drives sclk, fsync, data and the oversampling clock
`timescale 1ns/10ps
`default_nettype none
module sptx_src (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    sptx_if.src link,
    input wire logic [1:0] fmt_in,
    input wire logic [1:0] width_in,
    input wire logic osr_in,
    input wire logic [23:0] left_in,
    input wire logic [23:0] right_in,
    output logic take_out
);
    sptx_pkg::sptx_fmt_t fmt_r;
    sptx_pkg::sptx_width_t width_r;
    logic [4:0] cnt_r;
    logic sclk_r;
    logic [5:0] pos_r;
    logic [5:0] pos_nxt;
    logic fs_r;
    logic sd_r;
    logic [23:0] left_r;
    logic [23:0] right_r;
    logic take_r;
    logic [2:0] ocnt_r;
    logic [2:0] ohalf;
    logic oclk_r;
    logic fall;
    logic [5:0] p;
    logic [5:0] msb_slot;
    logic [5:0] bits;
    logic [5:0] bit_idx;
    logic [23:0] word;

    assign fall = sclk_r && (cnt_r == sptx_pkg::SPTX_SCLK_HALF_CYC - 5'h01);
    assign pos_nxt = pos_r + 6'h01;
    assign p = {1'b0, pos_nxt[4:0]};
    assign bits = sptx_pkg::sptx_word_bits(width_r);
    assign msb_slot = sptx_pkg::sptx_msb_slot(fmt_r, width_r);
    assign bit_idx = bits - 6'h01 - (p - msb_slot);
    assign word = pos_nxt[5] ? right_r : left_r;

    // sclk period is fixed at 24 clocks, above the 80 ns minimum
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            cnt_r <= 5'h00;
            sclk_r <= 1'b0;
        end else if (cnt_r == sptx_pkg::SPTX_SCLK_HALF_CYC - 5'h01) begin
            cnt_r <= 5'h00;
            sclk_r <= ~sclk_r;
        end else begin
            cnt_r <= cnt_r + 5'h01;
        end
    end

    // change on fall, stable at rise
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            pos_r <= sptx_pkg::SPTX_FRAME_SLOTS;
            fs_r <= 1'b0;
            sd_r <= 1'b0;
            take_r <= 1'b0;
            fmt_r <= sptx_pkg::SPTX_FMT_I2S;
            width_r <= sptx_pkg::SPTX_W16;
            left_r <= 24'h000000;
            right_r <= 24'h000000;
        end else begin
            take_r <= 1'b0;
            if (fall) begin
                pos_r <= pos_nxt;
                fs_r <= pos_nxt[5] ^ sptx_pkg::sptx_left_level(fmt_r);
                if (p >= msb_slot && p < msb_slot + bits) begin
                    sd_r <= word[bit_idx[4:0]];
                end else begin
                    sd_r <= 1'b0;
                end
                if (pos_nxt == sptx_pkg::SPTX_FRAME_SLOTS) begin
                    fmt_r <= sptx_pkg::sptx_fmt_t'(fmt_in);
                    width_r <= sptx_pkg::sptx_width_t'(width_in);
                    left_r <= left_in;
                    right_r <= right_in;
                    take_r <= 1'b1;
                end
            end
        end
    end

    // oclk at 256 or 384 fs
    assign ohalf = (osr_in == sptx_pkg::SPTX_OSR_384) ?
        sptx_pkg::SPTX_OCLK_HALF_384 : sptx_pkg::SPTX_OCLK_HALF_256;
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            ocnt_r <= 3'h0;
            oclk_r <= 1'b0;
        end else if (ocnt_r >= ohalf - 3'h1) begin
            ocnt_r <= 3'h0;
            oclk_r <= ~oclk_r;
        end else begin
            ocnt_r <= ocnt_r + 3'h1;
        end
    end

    assign link.sclk = sclk_r;
    assign link.fsync = fs_r;
    assign link.sdata = sd_r;
    assign link.oversample_clock = oclk_r;
    assign take_out = take_r;
endmodule : sptx_src
`default_nettype wire

// ### sim/sptx_link_chk.sv
// wire checks on the serial audio link between source and device ends
`timescale 1ns/10ps
`default_nettype none
module sptx_link_chk (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic sclk_in,
    input wire logic fsync_in,
    input wire logic sdata_in,
    input wire logic oversample_clock_in
);
    logic sclk;
    logic fsync;
    logic sdata;
    logic oversample_clock;
    assign sclk = sclk_in;
    assign fsync = fsync_in;
    assign sdata = sdata_in;
    assign oversample_clock = oversample_clock_in;
    logic fsync_d_r, sclk_d_r, oclk_d_r;
    logic [6:0] rise_cnt_r;
    logic [9:0] oclk_cnt_r;
    logic [1:0] seen_r;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    always_ff @(posedge clk_sys_in) begin
        fsync_d_r <= fsync;
        sclk_d_r <= sclk;
        oclk_d_r <= oversample_clock;
    end
    // first half frame after reset runs one bit clock long, so checks wait for seen_r
    // a format change that flips fsync polarity merges two halves; wait again
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in || rise_cnt_r > 7'h20) begin
            seen_r <= 2'h0;
        end else if (fsync != fsync_d_r) begin
            seen_r <= {seen_r[0], 1'b1};
        end
    end
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in || fsync != fsync_d_r) begin
            rise_cnt_r <= 7'h00;
        end else if (sclk && !sclk_d_r) begin
            rise_cnt_r <= rise_cnt_r + 7'h01;
        end
    end
    // osr may switch mid frame, so the per-frame count is a range
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in || (fsync && !fsync_d_r)) begin
            oclk_cnt_r <= 10'h000;
        end else if (oversample_clock && !oclk_d_r) begin
            oclk_cnt_r <= oclk_cnt_r + 10'h001;
        end
    end
    fsync_on_fall_a: assert property ($changed(fsync) |-> $fell(sclk))
        else $error("fsync moved away from a falling bit clock");
    sdata_on_fall_a: assert property ($changed(sdata) |-> $fell(sclk))
        else $error("data moved away from a falling bit clock");
    sclk_high_a: assert property ($rose(sclk) |-> sclk [*8] ##1 sclk [*4] ##1 !sclk)
        else $error("bit clock high time wrong");
    sclk_low_a: assert property ($fell(sclk) |-> ##12 $rose(sclk))
        else $error("bit clock low time wrong");
    half_frame_a: assert property ($changed(fsync) && seen_r[0] |-> rise_cnt_r == 7'h20)
        else $error("half frame not 32 bit clocks");
    oclk_period_a: assert property ($rose(oversample_clock) |=>
        (!$rose(oversample_clock)) [*3] ##[1:3] $rose(oversample_clock))
        else $error("oversampling clock period wrong");
    oclk_frame_a: assert property ($rose(fsync) && seen_r[1] |->
        oclk_cnt_r inside {[10'h0ff:10'h181]})
        else $error("oversampling clock rises per frame wrong");
    reset_idle_a: assert property (disable iff (1'b0) !rstn_in |=>
        !sclk && !fsync && !sdata && !oversample_clock)
        else $error("link not idle in reset");
    cover property ($rose(fsync));
    cover property ($fell(fsync));
    cover property ($rose(sclk) && sdata);
endmodule : sptx_link_chk
`default_nettype wire

// ### sim/tb_top.sv
// random and corner traffic through both ends of the serial audio link
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    logic clk_sys_in = 1'b0;
    logic rstn_in = 1'b0;
    logic fmt_sel = 1'b0;
    logic [1:0] src_fmt = 2'h0;
    logic [1:0] dev_fmt = 2'h0;
    logic [1:0] width = 2'h0;
    logic osr = 1'b0;
    logic [23:0] left_in = 24'h000000;
    logic [23:0] right_in = 24'h000000;
    logic [23:0] left_out, right_out;
    logic valid_out, tick_out, take_out;
    logic [47:0] cur_w, prev_w, exp_w;
    int err_total = 0;
    int n_compared = 0;
    int skip = 99;
    int good = 0;
    int ticks = 0;
    bit corner = 1'b0;
    bit is_rj = 1'b0;
    // {select, source format, device format, width}; first entry leans on the default
    logic [6:0] cfg [9] = '{7'h04, 7'h43, 7'h61, 7'h54, 7'h56, 7'h7c, 7'h7d, 7'h7e, 7'h7f};
    sptx_if i_sptx_if ();
    sptx_src i_sptx_src (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .link(i_sptx_if.src),
        .fmt_in(src_fmt), .width_in(width), .osr_in(osr), .left_in(left_in),
        .right_in(right_in), .take_out(take_out));
    sptx_dev i_sptx_dev (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .link(i_sptx_if.dev),
        .fmt_sel_in(fmt_sel), .fmt_in(dev_fmt), .width_in(width), .osr_in(osr),
        .left_out(left_out), .right_out(right_out), .valid_out(valid_out),
        .biphase_tick_out(tick_out));
    sptx_link_chk i_sptx_link_chk (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
        .sclk_in(i_sptx_if.sclk), .fsync_in(i_sptx_if.fsync), .sdata_in(i_sptx_if.sdata),
        .oversample_clock_in(i_sptx_if.oversample_clock));
    function automatic logic [23:0] wmask(input logic [1:0] w);
        case (w)
            2'h0: wmask = 24'h00ffff;
            2'h1: wmask = 24'h03ffff;
            2'h2: wmask = 24'h0fffff;
            default: wmask = 24'hffffff;
        endcase
    endfunction : wmask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude
    initial begin
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    // rj words finish after the next latch, so they pair with the older pair
    always @(negedge clk_sys_in) begin
        if (rstn_in) begin
            ticks = ticks + int'(tick_out === 1'b1);
            if (take_out === 1'b1) begin
                prev_w = cur_w;
                cur_w = {left_in, right_in};
                // one tick per 2 or 3 oversample rises
                if (skip == 0) `CHK("ticks per frame", 128, ticks)
                ticks = 0;
                left_in = corner ? 24'hffffff : 24'($urandom);
                right_in = corner ? 24'h800001 : 24'($urandom);
                corner = 1'b0;
            end
            if (valid_out === 1'b1) begin
                exp_w = (is_rj ? prev_w : cur_w) & {wmask(width), wmask(width)};
                if (skip > 0) begin
                    skip--;
                end else begin
                    // slot and channel placement per format
                    `CHK("left word", exp_w[47:24], left_out)
                    `CHK("right word", exp_w[23:0], right_out)
                    good++;
                end
            end
        end
    end
    initial begin
        repeat (100000) @(posedge clk_sys_in);
        err_total++;
        $display("Error watchdog expected done seen hang");
        conclude();
    end
    initial begin
        void'($urandom(43));
        repeat (6) @(negedge clk_sys_in);
        rstn_in = 1'b1;
        for (int i = 0; i < 9; i++) begin
            do @(negedge clk_sys_in); while (take_out !== 1'b1);
            {fmt_sel, src_fmt, dev_fmt, width} = cfg[i];
            osr = 1'($urandom);
            is_rj = fmt_sel && dev_fmt == 2'h3;
            corner = 1'b1;
            skip = 2;
            good = 0;
            for (int k = 0; k < 12000 && good < 2; k++) @(negedge clk_sys_in);
            // first entry runs without a format select
            `CHK("pairs seen", 1'b1, good >= 2)
        end
        conclude();
    end
endmodule : tb_top
`default_nettype wire
